// ### logic/apf_defines.svh
`ifndef APF_DEFINES_SVH
`define APF_DEFINES_SVH

// Register byte addresses
`define APF_ADDR_FILTER_CONFIG    16'h2044
`define APF_ADDR_RAW_RESULT       16'h2074
`define APF_ADDR_XFORM_REAL       16'h2078
`define APF_ADDR_XFORM_IMAG       16'h207C
`define APF_ADDR_NOTCH_RESULT     16'h2080
`define APF_ADDR_TEMP_RESULT      16'h2084
`define APF_ADDR_XFORM_CONFIG     16'h20D0
`define APF_ADDR_TEMP_CONFIG      16'h2174
`define APF_ADDR_CONV_CONFIG      16'h21A8
`define APF_ADDR_REPEAT_CTRL      16'h21F0
`define APF_ADDR_INBUF_CONFIG     16'h238C
`define APF_ADDR_AVG_CONTROL      16'h2200

// Reset values
`define APF_RST_FILTER_CONFIG     32'h0000_0301
`define APF_RST_XFORM_CONFIG      32'h0000_0090
`define APF_RST_REPEAT_CTRL       32'h0000_0160
`define APF_RST_INBUF_CONFIG      32'h005F_3D00
`define APF_RST_ZERO              32'h0000_0000

// Writable bits
`define APF_WMASK_FILTER_CONFIG   32'h0007_FFFF
`define APF_WMASK_AVG_CONTROL     32'h0000_0001
`define APF_WMASK_ALL             32'hFFFF_FFFF

// Field positions in the filter configuration register
`define APF_BIT_XFORM_GATE_N      18
`define APF_BIT_WAVEGEN_GATE_N    17
`define APF_BIT_NOTCH_GATE_N      16
`define APF_FLD_AVG_COUNT_HI      15
`define APF_FLD_AVG_COUNT_LO      14
`define APF_FLD_OSR1_HI           13
`define APF_FLD_OSR1_LO           12
`define APF_FLD_OSR2_HI           11
`define APF_FLD_OSR2_LO           8
`define APF_BIT_SINC3_OFF         6
`define APF_BIT_RATE_MODE         0

// Field position in the averaging control register
`define APF_BIT_AVG_ENABLE        0

`endif

// ### logic/apf_fifo.sv
`timescale 1ns/1ps

// Shift-register FIFO: head word is always a flop, flags are registered
module apf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int CW = $clog2(DEPTH + 1);

    // Elaboration check
    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("apf_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];  // Entry 0 is the head
    logic [CW-1:0]    cnt_r;          // Words held
    logic [CW-1:0]    cnt_nxt;
    logic             in_ready_r;
    logic             out_valid_r;

    wire push = ce & in_valid & in_ready_r;
    wire pop  = ce & out_ready & out_valid_r;

    // Count update from push and pop
    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + CW'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    // Flags and count; ready drops only when really full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r       <= '0;
            in_ready_r  <= 1'b1;
            out_valid_r <= 1'b0;
        end else if (ce) begin
            cnt_r       <= cnt_nxt;
            in_ready_r  <= (cnt_nxt != CW'(DEPTH));
            out_valid_r <= (cnt_nxt != '0);
        end
    end

    // Storage: pop shifts toward the head, push lands behind the last word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            // Shift loop stops short of the tail so no index leaves the array
            for (int i = 0; i < DEPTH - 1; i++) begin
                if (pop) begin
                    mem_r[i] <= mem_r[i+1];
                end
            end
            // Push comes later in the block, so it wins over the shift
            for (int i = 0; i < DEPTH; i++) begin
                if (push && CW'(i) == (pop ? cnt_r - CW'(1) : cnt_r)) begin
                    mem_r[i] <= in_data;
                end
            end
        end
    end

    assign in_ready  = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data  = mem_r[0];

endmodule // apf_fifo

// ### logic/apf_filter_ctrl.sv
`timescale 1ns/1ps
`include "apf_defines.svh"

module apf_filter_ctrl
    import apf_pkg::*;
#(
    parameter int ADDR_W   = 16,
    parameter int SAMPLE_W = 16,
    parameter int FIFO_D   = 4
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample_data,
    output logic                     sample_ready,
    output logic                     xform_valid,
    input  wire logic                xform_ready,
    output logic [SAMPLE_W-1:0]      xform_data,
    output logic                     xform_src_avg,
    output logic                     transform_clk_en,
    output logic                     wavegen_clk_en,
    output logic                     notch_filter_clk_en,
    output logic                     first_stage_enable,
    output logic                     first_stage_rate_mode,
    output logic [2:0]               first_stage_oversample_rate,
    output logic [9:0]               second_stage_oversample_count
);

    localparam int NREG  = 12;
    localparam int SUM_W = SAMPLE_W + 4;

    // Elaboration check: addresses need 14 bits at least
    if (ADDR_W < 14 || SAMPLE_W < 1 || FIFO_D < 2) begin : g_chk
        $error("apf_filter_ctrl parameters out of range");
    end

    // Byte address to register slot
    function automatic apf_idx_t addr_to_idx(input logic [15:0] a);
        case (a)
            `APF_ADDR_FILTER_CONFIG: addr_to_idx = idx_filter_config;
            `APF_ADDR_RAW_RESULT:    addr_to_idx = idx_raw_result;
            `APF_ADDR_XFORM_REAL:    addr_to_idx = idx_xform_real;
            `APF_ADDR_XFORM_IMAG:    addr_to_idx = idx_xform_imag;
            `APF_ADDR_NOTCH_RESULT:  addr_to_idx = idx_notch_result;
            `APF_ADDR_TEMP_RESULT:   addr_to_idx = idx_temp_result;
            `APF_ADDR_XFORM_CONFIG:  addr_to_idx = idx_xform_config;
            `APF_ADDR_TEMP_CONFIG:   addr_to_idx = idx_temp_config;
            `APF_ADDR_CONV_CONFIG:   addr_to_idx = idx_conv_config;
            `APF_ADDR_REPEAT_CTRL:   addr_to_idx = idx_repeat_ctrl;
            `APF_ADDR_INBUF_CONFIG:  addr_to_idx = idx_inbuf_config;
            `APF_ADDR_AVG_CONTROL:   addr_to_idx = idx_avg_control;
            default:                 addr_to_idx = idx_none;
        endcase
    endfunction

    // Reset value per slot
    function automatic logic [31:0] reset_of(input int i);
        case (i)
            int'(idx_filter_config): reset_of = `APF_RST_FILTER_CONFIG;
            int'(idx_xform_config):  reset_of = `APF_RST_XFORM_CONFIG;
            int'(idx_repeat_ctrl):   reset_of = `APF_RST_REPEAT_CTRL;
            int'(idx_inbuf_config):  reset_of = `APF_RST_INBUF_CONFIG;
            default:                 reset_of = `APF_RST_ZERO;
        endcase
    endfunction

    // Writable bits per slot
    function automatic logic [31:0] wmask_of(input apf_idx_t i);
        case (i)
            idx_filter_config: wmask_of = `APF_WMASK_FILTER_CONFIG;
            idx_avg_control:   wmask_of = `APF_WMASK_AVG_CONTROL;
            default:           wmask_of = `APF_WMASK_ALL;
        endcase
    endfunction

    // First-stage oversampling rate from its code
    function automatic logic [2:0] osr1_of(input logic [1:0] c);
        case (c)
            2'h0:    osr1_of = 3'h5;
            2'h1:    osr1_of = 3'h4;
            2'h2:    osr1_of = 3'h2;
            default: osr1_of = 3'h5;
        endcase
    endfunction

    // Second-stage sample count; unused codes clamp to the largest count
    function automatic logic [9:0] osr2_of(input logic [3:0] c);
        case (c)
            4'h0:    osr2_of = 10'd22;
            4'h1:    osr2_of = 10'd44;
            4'h2:    osr2_of = 10'd89;
            4'h3:    osr2_of = 10'd178;
            4'h4:    osr2_of = 10'd267;
            4'h5:    osr2_of = 10'd533;
            4'h6:    osr2_of = 10'd640;
            4'h7:    osr2_of = 10'd667;
            4'h8:    osr2_of = 10'd800;
            default: osr2_of = 10'd889;
        endcase
    endfunction

    // Register bank and bus answer flops
    logic [31:0] regs_r [NREG];
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;

    // Bus decode
    wire         acc_phase  = psel & penable;
    wire         first_acc  = acc_phase & ~pready_r;
    wire         wr_commit  = acc_phase & pready_r & pwrite & ~pslverr_r;
    wire [15:0]  addr16     = 16'(paddr);
    wire         addr_align = (paddr[1:0] == 2'b00);
    apf_idx_t    sel_idx;
    assign sel_idx = addr_align ? addr_to_idx(addr16) : idx_none;
    wire         unmapped   = (sel_idx == idx_none);
    wire [31:0]  rd_word    = unmapped ? 32'h0000_0000 : regs_r[sel_idx];
    wire [31:0]  wr_mask    = wmask_of(sel_idx);

    // Field views of the configuration
    wire [31:0] fcfg        = regs_r[idx_filter_config];
    wire        avg_en      = regs_r[idx_avg_control][`APF_BIT_AVG_ENABLE];
    wire [1:0]  avg_code    = fcfg[`APF_FLD_AVG_COUNT_HI:`APF_FLD_AVG_COUNT_LO];

    // Averager state
    logic [SUM_W-1:0] acc_r;   // Running sum
    logic [3:0]       cnt_r;   // Samples already summed
    logic             avg_en_d_r; // Detects enable changes to restart
    wire  [3:0]       last_cnt  = 4'((5'd2 << avg_code) - 5'd1);
    wire              take      = ce & sample_valid & sample_ready;
    wire              avg_mode  = avg_en;
    wire  [SUM_W-1:0] sum_now   = acc_r + SUM_W'(sample_data);
    wire              avg_done  = avg_mode & (cnt_r == last_cnt);
    // Shift is three bits wide so that code 3 divides by 16 and does not wrap
    wire  [SAMPLE_W-1:0] avg_word = SAMPLE_W'(sum_now >> (3'(avg_code) + 3'd1));

    // FIFO write side: averages while averaging, raw samples otherwise
    wire                push_v    = sample_valid & (avg_mode ? avg_done : 1'b1);
    wire [SAMPLE_W-1:0] push_data = avg_mode ? avg_word : sample_data;
    logic               fifo_ready;

    // Gate and decode flops for the outputs
    logic       xform_en_r;
    logic       wave_en_r;
    logic       notch_en_r;
    logic       fs_en_r;
    logic       fs_mode_r;
    logic [2:0] osr1_r;
    logic [9:0] osr2_r;
    apf_src_t   src_r;

    // APB answer: one wait state, data and error registered with ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r  <= first_acc;
            pslverr_r <= first_acc & unmapped;
            if (first_acc && !pwrite) begin
                prdata_r <= rd_word;
            end
        end
    end

    // Register writes; the sample capture wins over a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NREG; i++) begin
                regs_r[i] <= reset_of(i);
            end
        end else if (ce) begin
            if (wr_commit) begin
                regs_r[sel_idx] <= pwdata & wr_mask;
            end
            if (take) begin
                regs_r[idx_raw_result] <= 32'(sample_data);
            end
        end
    end

    // Averager: restarts whenever averaging is switched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r      <= '0;
            cnt_r      <= 4'h0;
            avg_en_d_r <= 1'b0;
        end else if (ce) begin
            avg_en_d_r <= avg_mode;
            if (avg_mode != avg_en_d_r || !avg_mode) begin
                acc_r <= '0;
                cnt_r <= 4'h0;
            end else if (take) begin
                if (avg_done) begin
                    acc_r <= '0;
                    cnt_r <= 4'h0;
                end else begin
                    acc_r <= sum_now;
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end

    // Control outputs, registered from the configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xform_en_r <= 1'b1;
            wave_en_r  <= 1'b1;
            notch_en_r <= 1'b1;
            fs_en_r    <= 1'b1;
            fs_mode_r  <= 1'b1;
            osr1_r     <= 3'h5;
            osr2_r     <= 10'd178;
            src_r      <= src_raw;
        end else if (ce) begin
            xform_en_r <= ~fcfg[`APF_BIT_XFORM_GATE_N];
            wave_en_r  <= ~fcfg[`APF_BIT_WAVEGEN_GATE_N];
            notch_en_r <= ~fcfg[`APF_BIT_NOTCH_GATE_N];
            fs_en_r    <= ~fcfg[`APF_BIT_SINC3_OFF];
            fs_mode_r  <= fcfg[`APF_BIT_RATE_MODE];
            osr1_r     <= osr1_of(fcfg[`APF_FLD_OSR1_HI:`APF_FLD_OSR1_LO]);
            osr2_r     <= osr2_of(fcfg[`APF_FLD_OSR2_HI:`APF_FLD_OSR2_LO]);
            src_r      <= avg_mode ? src_avg : src_raw;
        end
    end

    // Four-word buffer between sample path and transform input;
    // a full buffer holds off new samples, so nothing is dropped
    apf_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .in_valid  (push_v),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (xform_valid),
        .out_ready (xform_ready),
        .out_data  (xform_data)
    );

    // Sample intake stalls on a full buffer even mid-average, which
    // keeps the Nth sample from having nowhere to go
    assign sample_ready = fifo_ready;

    assign prdata                        = prdata_r;
    assign pready                        = pready_r;
    assign pslverr                       = pslverr_r;
    assign xform_src_avg                 = (src_r == src_avg);
    assign transform_clk_en              = xform_en_r;
    assign wavegen_clk_en                = wave_en_r;
    assign notch_filter_clk_en           = notch_en_r;
    assign first_stage_enable            = fs_en_r;
    assign first_stage_rate_mode         = fs_mode_r;
    assign first_stage_oversample_rate   = osr1_r;
    assign second_stage_oversample_count = osr2_r;

endmodule // apf_filter_ctrl

// ### logic/apf_pkg.sv
package apf_pkg;

    // Source feeding the transform engine input
    typedef enum logic {
        src_raw,
        src_avg
    } apf_src_t;

    // Register slots of the bank
    typedef enum logic [3:0] {
        idx_filter_config,
        idx_raw_result,
        idx_xform_real,
        idx_xform_imag,
        idx_notch_result,
        idx_temp_result,
        idx_xform_config,
        idx_temp_config,
        idx_conv_config,
        idx_repeat_ctrl,
        idx_inbuf_config,
        idx_avg_control,
        idx_none
    } apf_idx_t;

endpackage

// ### sim/apf_filter_ctrl_bench.sv
`timescale 1ns/1ps

module apf_filter_ctrl_bench
    import apf_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, hold_out = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0, sample_data = 16'h0, xform_data;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, sample_valid = 1'b0, sample_ready;
    logic        xform_valid, xform_ready = 1'b0, xform_src_avg;
    logic        transform_clk_en, wavegen_clk_en, notch_filter_clk_en;
    logic        first_stage_enable, first_stage_rate_mode;
    logic [2:0]  first_stage_oversample_rate;
    logic [9:0]  second_stage_oversample_count;
    int          errors = 0, checks = 0;
    logic [32:0] exp_rd[$];  // Expected read answers, oldest first
    logic [15:0] exp_st[$];  // Expected transform words
    // Register table: address, reset value, writable bits
    logic [15:0] addr_t[12] = '{16'h2044, 16'h2074, 16'h2078, 16'h207C, 16'h2080, 16'h2084,
                                16'h20D0, 16'h2174, 16'h21A8, 16'h21F0, 16'h238C, 16'h2200};
    logic [31:0] rst_t[12] = '{32'h0000_0301, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0090,
                               32'h0, 32'h0, 32'h0000_0160, 32'h005F_3D00, 32'h0};
    logic [31:0] mask_t[12] = '{32'h0007_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
                                32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
                                32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0001};
    logic [9:0]  osr2_t[10] = '{10'h016, 10'h02C, 10'h059, 10'h0B2, 10'h10B,
                                10'h215, 10'h280, 10'h29B, 10'h320, 10'h379};

    apf_filter_ctrl apf_filter_ctrl_i (.*);

    // 100 ns clock
    always #50 pclk = ~pclk;

    task automatic cmp(input string what, input logic [32:0] e, input logic [32:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic stop_test;
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One APB transfer; holds everything until pready is sampled
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [32:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // Offer one sample; valid stays up for a following call
    task automatic send(input logic [15:0] d);
        sample_valid <= 1'b1;
        sample_data <= d;
        @(posedge pclk);
        while (sample_ready !== 1'b1) @(posedge pclk);
    endtask

    // Decoded configuration outputs, after the one-clock follow delay
    task automatic chk_cfg(input logic [31:0] d);
        logic [2:0] o1;
        logic [9:0] o2;
        o1 = d[13:12] == 2'h1 ? 3'h4 : d[13:12] == 2'h2 ? 3'h2 : 3'h5;
        o2 = d[11:8] > 4'h9 ? 10'h379 : osr2_t[d[11:8]];
        repeat (3) @(posedge pclk);
        cmp("cfg_out", {15'h0, ~d[18:16], ~d[6], d[0], o1, o2},
            {15'h0, transform_clk_en, wavegen_clk_en, notch_filter_clk_en, first_stage_enable,
             first_stage_rate_mode, first_stage_oversample_rate,
             second_stage_oversample_count});
    endtask

    // Watcher: matches each read answer and each transform word to the oldest note
    always @(posedge pclk) begin
        if (presetn && ce && psel && penable && pready && !pwrite && exp_rd.size() > 0)
            cmp("prdata", exp_rd.pop_front(), {pslverr, prdata});
        if (presetn && ce && xform_valid && xform_ready) begin
            if (exp_st.size() > 0) cmp("xform_data", {17'h0, exp_st.pop_front()}, {17'h0, xform_data});
            else cmp("xform_extra", 33'h0, 33'h1);
        end
    end

    // Far side stalls at random unless held
    always @(posedge pclk) xform_ready <= hold_out ? 1'b0 : 1'($urandom % 2);

    initial begin
        logic [31:0] d;
        logic [19:0] sum;
        logic [15:0] s;
        d = $urandom(32'h8b7f);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk_cfg(32'h0000_0301);
        // Reset values, write, read back; averaging kept off
        for (int i = 0; i < 12; i++) begin
            rd(addr_t[i], {1'b0, rst_t[i]});
            d = $urandom;
            if (i == 11) d[0] = 1'b0;
            apb(1'b1, addr_t[i], d);
            rd(addr_t[i], {1'b0, d & mask_t[i]});
        end
        rd(16'h2048, {1'b1, 32'h0});
        rd(16'h2046, {1'b1, 32'h0});
        // Every first and second stage code
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            d[13:8] = {i[1:0], i[3:0]};
            apb(1'b1, 16'h2044, d);
            chk_cfg(d);
        end
        // Count 16 chosen but averaging off: words pass alone; fill until refused
        apb(1'b1, 16'h2044, 32'h0000_C301);
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            s = 16'($urandom);
            exp_st.push_back(s);
            if (i == 4) begin
                sample_valid <= 1'b0;
                repeat (3) @(posedge pclk);
                cmp("sample_ready", 33'h0, {32'h0, sample_ready});
                // Far side may pull now, but a frozen block must not pop
                ce <= 1'b0;
                hold_out <= 1'b0;
                repeat (6) @(posedge pclk);
                cmp("frozen_full", 33'h0, {32'h0, sample_ready});
                ce <= 1'b1;
            end
            send(s);
        end
        sample_valid <= 1'b0;
        while (exp_st.size() > 0) @(posedge pclk);
        cmp("src_avg", 33'h0, {32'h0, xform_src_avg});
        rd(16'h2074, {17'h0, s});
        // Averaging on: each count code in turn
        apb(1'b1, 16'h2200, 32'h0000_0001);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 16'h2044, {16'h0, k[1:0], 14'h0301});
            repeat (3) @(posedge pclk);
            cmp("src_avg", 33'h1, {32'h0, xform_src_avg});
            sum = 20'h0;
            for (int j = 0; j < (2 << k); j++) begin
                s = 16'($urandom);
                sum = sum + 20'(s);
                send(s);
            end
            exp_st.push_back(16'(sum >> (k + 1)));
            sample_valid <= 1'b0;
            while (exp_st.size() > 0) @(posedge pclk);
        end
        apb(1'b1, 16'h2200, 32'h0);
        repeat (3) @(posedge pclk);
        cmp("src_avg", 33'h0, {32'h0, xform_src_avg});
        stop_test;
    end

    // Hang guard, well beyond the expected run length
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        stop_test;
    end
endmodule // apf_filter_ctrl_bench

// ### sim/apf_filter_ctrl_properties.sv
`timescale 1ns/1ps

// Port-level checks on the filter control block
module apf_filter_ctrl_properties #(
    parameter int ADDR_W   = 16,
    parameter int SAMPLE_W = 16
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                ce,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                sample_ready,
    input wire logic                xform_valid,
    input wire logic                xform_ready,
    input wire logic [SAMPLE_W-1:0] xform_data,
    input wire logic                transform_clk_en,
    input wire logic                wavegen_clk_en,
    input wire logic                notch_filter_clk_en,
    input wire logic                first_stage_enable,
    input wire logic                first_stage_rate_mode,
    input wire logic [2:0]          first_stage_oversample_rate
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Completed write to the filter configuration word
    wire wr_cfg = psel && penable && pready && pwrite && ce && paddr == 16'h2044;

    // Answer comes one cycle after the first access cycle
    property p_ready_after_access;
        psel && penable && !pready && ce |=> pready;
    endproperty
    a_ready_after_access: assert property (p_ready_after_access) else $error("pready late");
    // Answer is a single-cycle pulse
    property p_ready_pulse;
        pready && ce |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    // Misaligned addresses are refused
    property p_err_misaligned;
        pready && paddr[1:0] != 2'h0 |-> pslverr;
    endproperty
    a_err_misaligned: assert property (p_err_misaligned) else $error("no error");
    // The configuration word is mapped
    property p_cfg_mapped;
        pready && paddr == 16'h2044 |-> !pslverr;
    endproperty
    a_cfg_mapped: assert property (p_cfg_mapped) else $error("config refused");
    // Upper bits of the configuration word always read back clear
    property p_reserved_zero;
        pready && !pwrite && paddr == 16'h2044 |-> prdata[31:19] == 13'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("upper bits set");
    // Gates follow written bits, inverted, two cycles on
    property p_gates;
        wr_cfg |=> ##1 transform_clk_en == !$past(pwdata[18], 2)
            && wavegen_clk_en == !$past(pwdata[17], 2)
            && notch_filter_clk_en == !$past(pwdata[16], 2);
    endproperty
    a_gates: assert property (p_gates) else $error("clock gate wrong");
    // First stage run flag and rate mode
    property p_first_stage;
        wr_cfg |=> ##1 first_stage_enable == !$past(pwdata[6], 2)
            && first_stage_rate_mode == $past(pwdata[0], 2);
    endproperty
    a_first_stage: assert property (p_first_stage) else $error("first stage wrong");
    // Rate decode 5,4,2,5
    property p_osr1;
        wr_cfg |=> ##1 first_stage_oversample_rate ==
            ($past(pwdata[13:12], 2) == 2'h1 ? 3'h4 : $past(pwdata[13:12], 2) == 2'h2 ? 3'h2 : 3'h5);
    endproperty
    a_osr1: assert property (p_osr1) else $error("rate decode wrong");
    // A stalled head word holds still
    property p_xform_hold;
        xform_valid && !xform_ready |=> xform_valid && $stable(xform_data);
    endproperty
    a_xform_hold: assert property (p_xform_hold) else $error("head word moved");
    // Clock enable low freezes the stream and bus answer
    property p_freeze;
        !ce |=> $stable(pready) && $stable(sample_ready) && $stable(xform_valid)
            && $stable(xform_data) && $stable(transform_clk_en);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    c_cfg_write: cover property (wr_cfg);
    c_refused: cover property (pslverr);
    c_pop: cover property (xform_valid && xform_ready);
    c_full: cover property (!sample_ready);
endmodule // apf_filter_ctrl_properties

bind apf_filter_ctrl apf_filter_ctrl_properties #(.ADDR_W(ADDR_W), .SAMPLE_W(SAMPLE_W)) chk_i (.*);
